// >>> core/fpl_host.sv
// Loading-host end of the fast parallel load link with an APB register slave
`timescale 1ns/1ns
module fpl_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    fpl_if.host              link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    import fpl_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_REQ, H_WST, H_LOAD, H_WDONE, H_FALL, H_PARK} hstate_t;

    logic [1:0] st_s;
    logic [1:0] dn_s;

    // Two-stage synchronisers for the device status and done outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_s <= 2'h0;
            dn_s <= 2'h0;
        end
        else if (ce)
        begin
            st_s <= {st_s[0], link.status_n};
            dn_s <= {dn_s[0], link.done};
        end
    end

    hstate_t     st_r, st_nxt;
    cnt_t        cnt_r, cnt_nxt;
    cnt_t        div_r, div_nxt;
    logic        lclk_r, lclk_nxt;
    logic        req_r, req_nxt;
    ratio_t      beat_r, beat_nxt;
    ratio_t      ratio_r, ratio_nxt;
    logic        cap_r, cap_nxt;
    logic        have_r, have_nxt;
    logic [31:0] data_r, data_nxt;
    logic [31:0] left_r, left_nxt;
    logic [31:0] len_r, len_nxt;
    logic [2:0]  ctrl_r, ctrl_nxt;
    logic [2:0]  irqs_r, irqs_nxt;
    logic [2:0]  mask_r, mask_nxt;
    logic [31:0] rd_nxt;
    logic        err_nxt;
    logic        acc;
    logic        wr;
    logic        busy;
    logic        ph_end;
    logic [2:0]  ev;

    assign busy   = (st_r != H_IDLE) && (st_r != H_PARK);
    // A data write waits while the previous word is still on the pins
    assign pready = !(psel && pwrite && paddr == A_DATA && have_r);
    assign acc    = psel && penable && pready;
    assign wr     = acc && pwrite;
    assign ph_end = (div_r + 20'h1 >= LCLK_HALF);

    // Sequencer, clock divider and register file
    always_comb
    begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        div_nxt   = div_r;
        lclk_nxt  = lclk_r;
        req_nxt   = req_r;
        beat_nxt  = beat_r;
        ratio_nxt = ratio_r;
        cap_nxt   = cap_r;
        have_nxt  = have_r;
        data_nxt  = data_r;
        left_nxt  = left_r;
        len_nxt   = len_r;
        ctrl_nxt  = ctrl_r;
        mask_nxt  = mask_r;
        rd_nxt    = 32'h0;
        err_nxt   = 1'b0;
        ev        = 3'h0;
        unique case (st_r)
            H_IDLE, H_PARK:
            begin
                lclk_nxt = 1'b0;
                div_nxt  = 20'h0;
            end
            H_REQ:
            begin
                cnt_nxt = cnt_r + 20'h1;
                if (cnt_r + 20'h1 >= CFG_CYC)
                begin
                    req_nxt = 1'b1;
                    st_nxt  = H_WST;
                    cnt_nxt = 20'h0;
                end
            end
            H_WST:
            begin
                cnt_nxt = st_s[1] ? cnt_r + 20'h1 : 20'h0;
                if (st_s[1] && cnt_r + 20'h1 >= ST2CK_CYC)
                    st_nxt = H_LOAD;
            end
            H_LOAD:
            begin
                div_nxt = ph_end ? 20'h0 : div_r + 20'h1;
                if (ph_end && !lclk_r)
                begin
                    if (left_r == 32'h0 && beat_r == 4'h0)
                    begin
                        st_nxt  = H_WDONE;
                        div_nxt = 20'h0;
                    end
                    else if (beat_r == 4'h0 && !have_r)
                        div_nxt = div_r;
                    else
                    begin
                        lclk_nxt = 1'b1;
                        cap_nxt  = (beat_r == 4'h0);
                        beat_nxt = beat_next(beat_r, ratio_r);
                    end
                end
                else if (ph_end)
                begin
                    lclk_nxt = 1'b0;
                    if (cap_r)
                    begin
                        cap_nxt  = 1'b0;
                        have_nxt = 1'b0;
                        left_nxt = left_r - 32'h1;
                    end
                end
            end
            H_WDONE:
            begin
                if (dn_s[1])
                begin
                    ev[IRQ_DONE] = 1'b1;
                    st_nxt       = H_FALL;
                    cnt_nxt      = 20'h0;
                end
            end
            H_FALL:
            begin
                div_nxt = ph_end ? 20'h0 : div_r + 20'h1;
                if (ph_end)
                begin
                    lclk_nxt = !lclk_r;
                    if (lclk_r)
                        cnt_nxt = cnt_r + 20'h1;
                    if (lclk_r && cnt_r + 20'h1 >= DONE_FALLS)
                    begin
                        st_nxt      = H_PARK;
                        ev[IRQ_FIN] = 1'b1;
                    end
                end
            end
        endcase
        // Status dropping mid-load means the device restarted
        if ((st_r == H_LOAD || st_r == H_WDONE) && !st_s[1])
        begin
            st_nxt      = H_IDLE;
            ev[IRQ_ERR] = 1'b1;
        end
        if (wr && paddr == A_CTRL)
        begin
            ctrl_nxt = {pwdata[CTRL_SECURE], pwdata[CTRL_DECOMP], 1'b0};
            if (pwdata[CTRL_START] && !busy)
            begin
                st_nxt    = H_REQ;
                req_nxt   = 1'b0;
                cnt_nxt   = 20'h0;
                beat_nxt  = 4'h0;
                cap_nxt   = 1'b0;
                lclk_nxt  = 1'b0;
                left_nxt  = len_r;
                ratio_nxt = ratio_of(pwdata[CTRL_DECOMP], pwdata[CTRL_SECURE]);
            end
        end
        if (wr && paddr == A_LEN)
            len_nxt = pwdata;
        if (wr && paddr == A_DATA)
        begin
            data_nxt = pwdata;
            have_nxt = 1'b1;
        end
        if (wr && paddr == A_MASK)
            mask_nxt = pwdata[2:0];
        // New events win over a write-one clear in the same cycle
        irqs_nxt = (irqs_r & ~((wr && paddr == A_IRQ) ? pwdata[2:0] : 3'h0)) | ev;
        // Answer registered in the setup cycle, so it stands at the taking edge
        if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                A_CTRL:  rd_nxt = {29'h0, ctrl_r};
                A_LEN:   rd_nxt = len_r;
                A_STAT:  rd_nxt = {25'h0, have_r, st_r, dn_s[1], st_s[1], busy};
                A_IRQ:   rd_nxt = {29'h0, irqs_r};
                A_MASK:  rd_nxt = {29'h0, mask_r};
                default: err_nxt = 1'b1;
            endcase
        end
        else if (psel && !penable && !(paddr inside {A_CTRL, A_LEN, A_DATA, A_IRQ, A_MASK}))
            err_nxt = 1'b1;
        else if (psel && penable)
        begin
            rd_nxt  = prdata;
            err_nxt = pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r    <= H_IDLE;
            cnt_r   <= 20'h0;
            div_r   <= 20'h0;
            lclk_r  <= 1'b0;
            req_r   <= 1'b1;
            beat_r  <= 4'h0;
            ratio_r <= 4'h1;
            cap_r   <= 1'b0;
            have_r  <= 1'b0;
            data_r  <= 32'h0;
            left_r  <= 32'h0;
            len_r   <= 32'h0;
            ctrl_r  <= 3'h0;
            irqs_r  <= IRQ_RST;
            mask_r  <= IRQ_RST;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            div_r   <= div_nxt;
            lclk_r  <= lclk_nxt;
            req_r   <= req_nxt;
            beat_r  <= beat_nxt;
            ratio_r <= ratio_nxt;
            cap_r   <= cap_nxt;
            have_r  <= have_nxt;
            data_r  <= data_nxt;
            left_r  <= left_nxt;
            len_r   <= len_nxt;
            ctrl_r  <= ctrl_nxt;
            irqs_r  <= irqs_nxt;
            mask_r  <= mask_nxt;
            prdata  <= rd_nxt;
            pslverr <= err_nxt;
        end
    end

    assign link.req_n      = req_r;
    assign link.load_clock = lclk_r;
    assign link.data       = data_r;
    assign irq             = |(irqs_r & mask_r);
endmodule

// >>> core/fpl_pkg.sv
// Shared constants, types and helpers for the fast parallel loader link
package fpl_pkg;
    typedef logic [19:0] cnt_t;
    typedef logic [3:0]  ratio_t;
    localparam int   CLK_NS      = 4;
    localparam int   T_CFG_NS    = 2000;    // Least request low time
    localparam int   T_ST2CK_NS  = 2000;    // Least status high to first rise
    localparam int   T_STATUS_NS = 268000;  // Least status low time
    localparam int   T_CD2UM_NS  = 175000;  // Least done to user mode
    localparam int   T_CD2CU_NS  = 4 * 10;  // Four slowest load clock periods
    localparam cnt_t CFG_CYC     = cnt_t'((T_CFG_NS + CLK_NS - 1) / CLK_NS);
    localparam cnt_t ST2CK_CYC   = cnt_t'((T_ST2CK_NS + CLK_NS - 1) / CLK_NS);
    localparam cnt_t STATUS_CYC  = cnt_t'((T_STATUS_NS + CLK_NS - 1) / CLK_NS);
    localparam cnt_t CD2UM_CYC   = cnt_t'((T_CD2UM_NS + CLK_NS - 1) / CLK_NS);
    localparam cnt_t CD2CU_CYC   = cnt_t'((T_CD2CU_NS + CLK_NS - 1) / CLK_NS);
    localparam cnt_t USR_EDGES   = cnt_t'(8576);
    localparam cnt_t LCLK_HALF   = cnt_t'(4);  // Base clock cycles per load clock phase
    localparam cnt_t DONE_FALLS  = cnt_t'(2);
    // Host register map and fields
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_LEN  = 8'h04;
    localparam logic [7:0] A_DATA = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0c;
    localparam logic [7:0] A_IRQ  = 8'h10;
    localparam logic [7:0] A_MASK = 8'h14;
    localparam int CTRL_START  = 0;
    localparam int CTRL_DECOMP = 1;
    localparam int CTRL_SECURE = 2;
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_ERR     = 1;
    localparam int IRQ_FIN     = 2;
    localparam logic [2:0] IRQ_RST = 3'h0;
    // Bus width modes
    localparam logic [1:0] W8  = 2'h0;
    localparam logic [1:0] W16 = 2'h1;

    // Clock-to-data ratio from the decompression and security settings
    function automatic ratio_t ratio_of(input logic decomp, input logic secure);
        ratio_of = decomp ? 4'h8 : (secure ? 4'h4 : 4'h1);
    endfunction

    // Next beat of a ratio group, wrapping to zero
    function automatic ratio_t beat_next(input ratio_t b, input ratio_t r);
        beat_next = (b + 4'h1 >= r) ? 4'h0 : b + 4'h1;
    endfunction
endpackage

// >>> core/fpl_if.sv
// Link pins between the loading host and the configured device
`timescale 1ns/1ns
interface fpl_if;
    logic        req_n;        // Reconfiguration request, host driven
    logic        status_n_o;   // Device status drive value
    logic        status_n_oe;  // Device drives status low
    logic        status_n;     // Resolved open-drain status with pull-up
    logic        done;         // Configuration done
    logic        load_clock;   // Host driven load clock
    logic [31:0] data;         // Image data
    logic        init_done_n;  // Initialization complete pin

    assign status_n = (status_n_oe && !status_n_o) ? 1'b0 : 1'b1;

    modport device (input req_n, load_clock, data, status_n,
                    output status_n_o, status_n_oe, done, init_done_n);
    modport host (output req_n, load_clock, data,
                  input status_n, done, init_done_n);
endinterface

// >>> core/fpl_device.sv
// Configured-device end of the fast parallel load link
// Operation
// - Host clocks r times the data rate
// - Extra clocks per word spent decoding
// - Host stops clock r-1 clocks after last
// - Done and status low within 600 ns
// - Host holds request low 2 us
// - Status low between 268 and 1506 us
// - Status released after request high
// - Host waits 2 us after status rise
// - Load clock speed and duty limits
// - Oscillator init: user mode 175-437 us
// - User clock init: delay then 8576 edges
// - User mode lines high; request restarts
// - Status low for power-on delay
// - Done low until loading completes
// - Host parks clock at fixed level
// - Pause by clock low, data before rise
// - Done after full image, two falls
// - Init pin low once option loaded
`timescale 1ns/1ns
module fpl_device #(
    parameter fpl_pkg::cnt_t POR_CYC        = fpl_pkg::STATUS_CYC,
    parameter fpl_pkg::cnt_t STATUS_LOW_CYC = fpl_pkg::STATUS_CYC,
    parameter fpl_pkg::cnt_t INIT_OSC_CYC   = fpl_pkg::CD2UM_CYC,
    parameter fpl_pkg::cnt_t USR_INIT_EDGES = fpl_pkg::USR_EDGES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    fpl_if.device            link,
    input  wire logic        decomp,
    input  wire logic        secure,
    input  wire logic [1:0]  bus_width,
    input  wire logic [31:0] image_words,
    input  wire logic        user_clk_opt,
    input  wire logic        user_init_clock,
    output logic      [31:0] word_o,
    output logic             word_valid,
    output logic             user_mode
);
    import fpl_pkg::*;

    typedef enum logic [2:0] {D_POR, D_CLEAR, D_WREL, D_LOAD, D_EDGES, D_INIT, D_USER} dstate_t;

    // Pin synchronisers: stage one feeds only stage two
    logic [2:0]  lclk_s;
    logic [1:0]  req_s;
    logic [1:0]  uclk_s;
    logic        uclk_d;
    logic [31:0] data_s1;
    logic [31:0] data_s2;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lclk_s  <= 3'h0;
            req_s   <= 2'h3;
            uclk_s  <= 2'h0;
            uclk_d  <= 1'b0;
            data_s1 <= 32'h0;
            data_s2 <= 32'h0;
        end
        else if (ce)
        begin
            lclk_s  <= {lclk_s[1:0], link.load_clock};
            req_s   <= {req_s[0], link.req_n};
            uclk_s  <= {uclk_s[0], user_init_clock};
            uclk_d  <= uclk_s[1];
            data_s1 <= link.data;
            data_s2 <= data_s1;
        end
    end

    logic lrise;
    logic lfall;
    logic urise;
    logic req_lo;
    assign lrise  = lclk_s[1] && !lclk_s[2];
    assign lfall  = !lclk_s[1] && lclk_s[2];
    assign urise  = uclk_s[1] && !uclk_d;
    assign req_lo = !req_s[1];

    dstate_t     st_r, st_nxt;
    cnt_t        cnt_r, cnt_nxt;
    ratio_t      beat_r, beat_nxt;
    ratio_t      ratio_r, ratio_nxt;
    logic [31:0] cap_r, cap_nxt;
    logic [31:0] nwords_r, nwords_nxt;
    logic [31:0] word_nxt;
    logic        wv_r, wv_nxt;
    logic        first_r, first_nxt;
    logic        idn_en_r, idn_en_nxt;
    logic        ucen_r, ucen_nxt;
    logic [31:0] din;

    // Narrow bus modes see only their low lanes
    always_comb
    begin
        unique case (bus_width)
            W8:      din = {24'h0, data_s2[7:0]};
            W16:     din = {16'h0, data_s2[15:0]};
            default: din = data_s2;
        endcase
    end

    // Sequencer: reset handshake, loading, initialization
    always_comb
    begin
        st_nxt     = st_r;
        cnt_nxt    = cnt_r;
        beat_nxt   = beat_r;
        ratio_nxt  = ratio_r;
        cap_nxt    = cap_r;
        nwords_nxt = nwords_r;
        word_nxt   = word_o;
        wv_nxt     = 1'b0;
        first_nxt  = first_r;
        idn_en_nxt = idn_en_r;
        ucen_nxt   = ucen_r;
        unique case (st_r)
            D_POR:
            begin
                cnt_nxt = cnt_r + 20'h1;
                if (cnt_r + 20'h1 >= POR_CYC)
                    st_nxt = D_WREL;
            end
            D_CLEAR:
            begin
                cnt_nxt = cnt_r + 20'h1;
                if (cnt_r + 20'h1 >= STATUS_LOW_CYC)
                    st_nxt = D_WREL;
            end
            D_WREL:
            begin
                // Status stays low while the request is held low
                if (!req_lo)
                begin
                    st_nxt     = D_LOAD;
                    ratio_nxt  = ratio_of(decomp, secure);
                    beat_nxt   = 4'h0;
                    nwords_nxt = 32'h0;
                    first_nxt  = 1'b1;
                    idn_en_nxt = 1'b0;
                end
            end
            D_LOAD:
            begin
                // A paused clock simply yields no rise here
                if (lrise)
                begin
                    beat_nxt = beat_next(beat_r, ratio_r);
                    if (beat_r == 4'h0)
                    begin
                        cap_nxt   = din;
                        first_nxt = 1'b0;
                        if (first_r && din[0])
                            idn_en_nxt = 1'b1;
                    end
                    // Word leaves only after its decode beats elapse
                    if (beat_next(beat_r, ratio_r) == 4'h0)
                    begin
                        word_nxt   = (beat_r == 4'h0) ? din : cap_r;
                        wv_nxt     = 1'b1;
                        nwords_nxt = nwords_r + 32'h1;
                        if (nwords_r + 32'h1 >= image_words)
                        begin
                            st_nxt  = D_EDGES;
                            cnt_nxt = 20'h0;
                        end
                    end
                end
            end
            D_EDGES:
            begin
                if (lfall)
                begin
                    cnt_nxt = cnt_r + 20'h1;
                    if (cnt_r + 20'h1 >= DONE_FALLS)
                    begin
                        st_nxt   = D_INIT;
                        cnt_nxt  = 20'h0;
                        ucen_nxt = 1'b0;
                    end
                end
            end
            D_INIT:
            begin
                if (!user_clk_opt)
                begin
                    cnt_nxt = cnt_r + 20'h1;
                    if (cnt_r + 20'h1 >= INIT_OSC_CYC)
                        st_nxt = D_USER;
                end
                else if (!ucen_r)
                begin
                    cnt_nxt = cnt_r + 20'h1;
                    if (cnt_r + 20'h1 >= CD2CU_CYC)
                    begin
                        ucen_nxt = 1'b1;
                        cnt_nxt  = 20'h0;
                    end
                end
                else if (urise)
                begin
                    cnt_nxt = cnt_r + 20'h1;
                    if (cnt_r + 20'h1 >= USR_INIT_EDGES)
                        st_nxt = D_USER;
                end
            end
            D_USER:
            begin
            end
        endcase
        // Request low restarts from any state except power-on and the clear wait
        if (req_lo && st_r != D_POR && st_r != D_CLEAR)
        begin
            st_nxt  = D_CLEAR;
            cnt_nxt = 20'h0;
            idn_en_nxt = 1'b0;  // Init pin must not fall while status is low
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r     <= D_POR;
            cnt_r    <= 20'h0;
            beat_r   <= 4'h0;
            ratio_r  <= 4'h1;
            cap_r    <= 32'h0;
            nwords_r <= 32'h0;
            word_o   <= 32'h0;
            wv_r     <= 1'b0;
            first_r  <= 1'b0;
            idn_en_r <= 1'b0;
            ucen_r   <= 1'b0;
        end
        else if (ce)
        begin
            st_r     <= st_nxt;
            cnt_r    <= cnt_nxt;
            beat_r   <= beat_nxt;
            ratio_r  <= ratio_nxt;
            cap_r    <= cap_nxt;
            nwords_r <= nwords_nxt;
            word_o   <= word_nxt;
            wv_r     <= wv_nxt;
            first_r  <= first_nxt;
            idn_en_r <= idn_en_nxt;
            ucen_r   <= ucen_nxt;
        end
    end

    // Pin drive follows state, a few cycles after a request edge
    assign link.status_n_o  = 1'b0;
    assign link.status_n_oe = (st_r == D_POR) || (st_r == D_CLEAR) ||
                              (st_r == D_WREL);
    assign link.done        = (st_r == D_EDGES) || (st_r == D_INIT) ||
                              (st_r == D_USER);
    assign link.init_done_n = !(idn_en_r && st_r != D_USER);
    assign word_valid       = wv_r;
    assign user_mode        = (st_r == D_USER);
endmodule

// >>> sim/fpl_link_assertions.sv
// Timing checks on the fast parallel load link pins
`timescale 1ns/1ns
module fpl_link_assertions #(
    parameter int LOW_CYC = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req_n,
    input wire logic status_n,
    input wire logic done,
    input wire logic load_clock,
    input wire logic init_done_n
);
    localparam int REL_MAX = LOW_CYC + 8;
    logic [19:0] low_r;
    logic [19:0] req_r;
    logic [19:0] hi_r;
    logic [19:0] low_nxt;
    logic [19:0] req_nxt;
    logic [19:0] hi_nxt;
    // Run lengths of status low, request low and status high
    always_comb
    begin
        low_nxt = status_n ? 20'h0 : low_r + 20'h1;
        req_nxt = req_n ? 20'h0 : req_r + 20'h1;
        hi_nxt  = status_n ? hi_r + 20'h1 : 20'h0;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_r <= 20'h0;
            req_r <= 20'h0;
            hi_r  <= 20'h0;
        end
        else
        begin
            low_r <= low_nxt;
            req_r <= req_nxt;
            hi_r  <= hi_nxt;
        end
    end
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_req_drop: assert property ($fell(req_n) |-> ##[0:150] (!done && !status_n))
        else $error("done or status late after request");
    chk_status_min: assert property ($rose(status_n) |-> low_r >= LOW_CYC)
        else $error("status low too short");
    chk_status_free: assert property ($rose(req_n) |-> ##[0:REL_MAX] status_n)
        else $error("status not released");
    chk_done_hold: assert property (req_n && !status_n |-> !done)
        else $error("done high while status low");
    chk_user_lines: assert property (done && req_n |-> status_n)
        else $error("status low in user mode");
    chk_init_pin: assert property ($fell(init_done_n) |-> !done && status_n)
        else $error("init pin fell outside load");
    chk_req_width: assert property ($rose(req_n) |-> req_r >= 500)
        else $error("request low too short");
    chk_first_clk: assert property ($rose(load_clock) && !done |-> hi_r >= 500)
        else $error("load clock too soon after status");
endmodule

// >>> sim/test_fast_parallel_config_load.sv
// Bench: APB-driven host loading the device over the link
`timescale 1ns/1ns
module test_fast_parallel_config_load;
    import fpl_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        ce = 1'b1;
    logic [31:0] n_words = 32'h2;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic        decomp = 1'b0;
    logic        secure = 1'b0;
    logic [1:0]  bus_width = 2'h2;
    logic        user_clk_opt = 1'b0;
    logic        user_init_clock = 1'b0;
    logic [31:0] prdata;
    logic [31:0] word_o;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        word_valid;
    logic        user_mode;
    logic        err;
    logic [31:0] got[$];
    int          n_mismatch = 0;
    int          check_count = 0;
    fpl_if link();
    fpl_device #(.POR_CYC(20'd24), .STATUS_LOW_CYC(20'd20), .INIT_OSC_CYC(20'd20), .USR_INIT_EDGES(20'd20))
    fpl_device_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .link(link), .decomp(decomp), .secure(secure),
        .bus_width(bus_width), .image_words(n_words), .user_clk_opt(user_clk_opt),
        .user_init_clock(user_init_clock), .word_o(word_o), .word_valid(word_valid), .user_mode(user_mode));
    fpl_host fpl_host_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .link(link), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));
    fpl_link_assertions #(.LOW_CYC(20)) fpl_link_assertions_inst (.pclk(pclk), .presetn(presetn),
        .req_n(link.req_n), .status_n(link.status_n), .done(link.done), .load_clock(link.load_clock),
        .init_done_n(link.init_done_n));
    // Clocks; the user clock is offset so its edges never meet pclk edges
    always #2 pclk = ~pclk;
    initial
    begin
        #7;
        forever #40 user_init_clock = ~user_init_clock;
    end
    // Collect every decoded word
    always @(posedge pclk)
        if (word_valid === 1'b1)
            got.push_back(word_o);
    task automatic cmp(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One APB transfer; the answer is taken at the edge where pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 4000);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        n_mismatch += int'(n >= 4000);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Full load of nw words; the device is told the same image length
    task automatic load(input logic dc, input logic sc, input logic [1:0] bw, input logic uo,
                        input logic [31:0] msk, input logic [2:0] mask, input int nw);
        int k;
        @(posedge pclk);
        decomp <= dc;
        secure <= sc;
        bus_width <= bw;
        user_clk_opt <= uo;
        n_words <= 32'(nw);
        got.delete();
        apb(1'b1, A_MASK, {29'h0, mask});
        apb(1'b1, A_LEN, 32'(nw));
        apb(1'b1, A_CTRL, {29'h0, sc, dc, 1'b1});
        for (k = 0; k < nw; k++)
            apb(1'b1, A_DATA, 32'h13579bd1 ^ 32'(k << 8));
        k = 0;
        do
        begin
            apb(1'b0, A_IRQ, 32'h0);
            k++;
        end
        while (rd[IRQ_FIN] !== 1'b1 && k < 3000);
        cmp("irq_status", rd, 32'h5);
        cmp("irq_line", {31'h0, irq}, {31'h0, |(mask & 3'h5)});
        cmp("word_count", 32'(got.size()), 32'(nw));
        for (k = 0; k < nw; k++)
            cmp("word", got[k], (32'h13579bd1 ^ 32'(k << 8)) & msk);
        k = 0;
        while (user_mode !== 1'b1 && k < 3000)
        begin
            @(posedge pclk);
            k++;
        end
        cmp("user_mode", {31'h0, user_mode}, 32'h1);
        cmp("done_line", {31'h0, link.done}, 32'h1);
        cmp("init_pin", {31'h0, link.init_done_n}, 32'h1);
        apb(1'b0, A_CTRL, 32'h0);
        cmp("ctrl", rd, {29'h0, sc, dc, 1'b0});
        apb(1'b1, A_IRQ, 32'h7);
        apb(1'b0, A_IRQ, 32'h0);
        cmp("irq_clear", rd, 32'h0);
    endtask
    // Timeout
    initial
    begin
        repeat (60000) @(posedge pclk);
        n_mismatch++;
        summarize();
    end
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        ce <= 1'b0;
        // A low clock enable must hold the device in its power-on wait
        repeat (40) @(posedge pclk);
        cmp("por_freeze", {31'h0, link.status_n}, 32'h0);
        ce <= 1'b1;
        apb(1'b0, 8'h20, 32'h0);
        cmp("slverr_unmapped", {31'h0, err}, 32'h1);
        apb(1'b0, A_DATA, 32'h0);
        cmp("slverr_data", {31'h0, err}, 32'h1);
        load(1'b0, 1'b0, 2'h2, 1'b0, 32'hffffffff, 3'h7, 2);
        load(1'b1, 1'b0, W8, 1'b1, 32'h000000ff, 3'h0, 2);
        load(1'b0, 1'b1, W16, 1'b0, 32'h0000ffff, 3'h3, 3);
        summarize();
    end
endmodule
